// ===== verilog/adc_host_pkg.sv
package adc_host_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ   = 250;
   localparam int unsigned T_W_NS    = 300;
   localparam int unsigned T_DH_NS   = 10;
   localparam int unsigned T_DC_NS   = 700;
   localparam int unsigned T_C_NS    = 10000;
   localparam int unsigned T_TD_NS   = 250;
   localparam int unsigned T_DT_NS   = 150;
   localparam int unsigned T_W_CYC   = (T_W_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_DH_CYC  = (T_DH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_CV_CYC  = ((T_DC_NS + T_C_NS) * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_TD_CYC  = (T_TD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_DT_CYC  = (T_DT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W     = 12;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] CMD_OFS     = 12'h000;
   localparam logic [11:0] BASE_OFS    = 12'h004;
   localparam logic [11:0] MUXADR_OFS  = 12'h008;
   localparam logic [11:0] STATUS_OFS  = 12'h00c;
   localparam logic [11:0] RESULT_OFS  = 12'h010;

   localparam int unsigned CMD_CONV_BIT   = 8;
   localparam int unsigned CMD_MUX_BIT    = 9;
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_DONE_BIT    = 1;
   localparam int unsigned ST_CONV_BIT    = 2;
   localparam int unsigned ST_CHAN_LSB    = 8;
   localparam int unsigned ST_MODE_LSB    = 16;
   localparam int unsigned IO_ADDR_W      = 10;

   localparam logic [9:0] CONV_BASE_RST = 10'h310;
   localparam logic [9:0] MUX_ADDR_RST  = 10'h318;

   // ----------------------------------------
   // start byte fields
   // ----------------------------------------
   localparam int unsigned BIPOLAR_RANGE_SELECT_BIT = 0;
   localparam int unsigned CODING_SELECT_BIT        = 1;
   localparam int unsigned MODE_W                   = 2;
   localparam int unsigned CHAN_W                   = 2;
   localparam logic [1:0] MODE_UNI_STRAIGHT = 2'h0;
   localparam logic [1:0] MODE_BIP_OFFSET   = 2'h1;
   localparam logic [1:0] MODE_UNI_TWOS     = 2'h2;
   localparam logic [1:0] MODE_BIP_TWOS     = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WR_STROBE,
      ST_WR_HOLD,
      ST_CONV_WAIT,
      ST_STATUS_WAIT,
      ST_RD_STROBE,
      ST_RECOVER
   } state_t;

endpackage

// ===== verilog/adc_io_glue.sv
`timescale 1ns/1ps

module adc_io_glue (
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic [9:0] io_addr_i,
   input  wire logic       io_address_enable_n_i,
   input  wire logic       io_read_strobe_i,
   input  wire logic       io_write_strobe_i,
   input  wire logic       io_drive_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic [9:0] conv_base_i,
   input  wire logic [9:0] mux_addr_i,
   input  wire logic       conv_status_i,
   output logic            conv_cs_n_o,
   output logic            conv_ce_n_o,
   output logic            conv_rw_o,
   output logic [7:0]      conv_data_o,
   output logic            conv_data_oe_o,
   output logic [1:0]      mux_chan_o,
   output logic            sample_o
);

   typedef struct packed {
      logic       cs_n;
      logic       ce_n;
      logic       rw;
      logic [7:0] data;
      logic       data_oe;
      logic [1:0] chan;
      logic       sample;
   } glue_t;

   glue_t q;
   glue_t d;
   logic  conv_hit;
   logic  mux_hit;

   // ----------------------------------------
   // decode and strobes
   // ----------------------------------------
   always_comb begin
      d        = q;
      conv_hit = !io_address_enable_n_i
                 && (io_addr_i[9:1] == conv_base_i[9:1]);
      mux_hit  = !io_address_enable_n_i && (io_addr_i == mux_addr_i);
      d.cs_n   = !conv_hit;
      d.rw     = io_addr_i[0];
      d.ce_n   = !(conv_hit && (io_read_strobe_i || io_write_strobe_i));
      d.data    = io_wdata_i;
      d.data_oe = io_drive_i && (conv_hit || mux_hit) && !io_addr_i[0];
      if (mux_hit && io_write_strobe_i) begin
         d.chan = io_wdata_i[adc_host_pkg::CHAN_W-1:0];
      end
      d.sample = !conv_status_i;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '{cs_n: 1'b1, ce_n: 1'b1, rw: 1'b1, data: 8'h00,
                data_oe: 1'b0, chan: 2'h0, sample: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign conv_cs_n_o    = q.cs_n;
   assign conv_ce_n_o    = q.ce_n;
   assign conv_rw_o      = q.rw;
   assign conv_data_o    = q.data;
   assign conv_data_oe_o = q.data_oe;
   assign mux_chan_o     = q.chan;
   assign sample_o       = q.sample;

endmodule

// ===== verilog/adc_host_ctrl.sv
// Summary of operation
// - decode from low ten address lines
// - address enable masks dma cycles
// - address bit zero drives direction
// - read and write strobes drive enable
// - data bits zero, one carry mode
// - wait ten microseconds before reading result
// - mux decode plus write latches channel
// - channel held until next mux write
// - sample/hold is inverted status
// - status to hold under 150 ns
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps

module adc_host_ctrl (
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        io_address_enable_n_i,
   input  wire logic        conv_status_i,
   input  wire logic [7:0]  conv_data_i,
   output logic             conv_cs_n_o,
   output logic             conv_ce_n_o,
   output logic             conv_rw_o,
   output logic [7:0]       conv_data_o,
   output logic             conv_data_oe_o,
   output logic [1:0]       mux_chan_o,
   output logic             sample_o
);

   localparam int unsigned CW = adc_host_pkg::CNT_W;

   typedef struct packed {
      adc_host_pkg::state_t state;
      logic [CW-1:0]        cnt;
      logic                 conv_op;
      logic                 pend_conv;
      logic                 pend_mux;
      logic [9:0]           io_addr;
      logic                 io_read_strobe;
      logic                 io_write_strobe;
      logic                 drive;
      logic [7:0]           wdata;
      logic [7:0]           cmd_byte;
      logic [9:0]           base;
      logic [9:0]           mux_addr;
      logic [7:0]           result;
      logic [1:0]           mode;
      logic                 done;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } ctrl_t;

   ctrl_t q;
   ctrl_t d;

   logic acc;
   logic commit;
   logic busy;

   // ----------------------------------------
   // control sequencer and register slave
   // ----------------------------------------
   always_comb begin
      d      = q;
      acc    = psel_i && penable_i;
      commit = acc && q.pready;
      busy   = (q.state != adc_host_pkg::ST_IDLE)
               || q.pend_conv || q.pend_mux;

      // answer one cycle into the access phase
      d.pready  = acc && !q.pready;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      if (acc && !q.pready) begin
         case (paddr_i)
            adc_host_pkg::CMD_OFS: begin
               d.prdata[7:0] = q.cmd_byte;
            end
            adc_host_pkg::BASE_OFS: begin
               d.prdata[9:0] = q.base;
            end
            adc_host_pkg::MUXADR_OFS: begin
               d.prdata[9:0] = q.mux_addr;
            end
            adc_host_pkg::STATUS_OFS: begin
               d.prdata[adc_host_pkg::ST_BUSY_BIT] = busy;
               d.prdata[adc_host_pkg::ST_DONE_BIT] = q.done;
               d.prdata[adc_host_pkg::ST_CONV_BIT] = conv_status_i;
               d.prdata[adc_host_pkg::ST_CHAN_LSB +: adc_host_pkg::CHAN_W] =
                  mux_chan_o;
               d.prdata[adc_host_pkg::ST_MODE_LSB +: adc_host_pkg::MODE_W] =
                  q.mode;
            end
            adc_host_pkg::RESULT_OFS: begin
               d.prdata[7:0] = q.result;
            end
            default: begin
               d.pslverr = 1'b1;
            end
         endcase
      end

      // register writes land at the edge that sees pready
      if (commit && pwrite_i) begin
         case (paddr_i)
            adc_host_pkg::CMD_OFS: begin
               if (!busy) begin
                  d.cmd_byte  = pwdata_i[7:0];
                  d.pend_conv = pwdata_i[adc_host_pkg::CMD_CONV_BIT];
                  d.pend_mux  = pwdata_i[adc_host_pkg::CMD_MUX_BIT]
                                && !pwdata_i[adc_host_pkg::CMD_CONV_BIT];
                  if (pwdata_i[adc_host_pkg::CMD_CONV_BIT]
                      || pwdata_i[adc_host_pkg::CMD_MUX_BIT]) begin
                     d.done = 1'b0;
                  end
               end
            end
            adc_host_pkg::BASE_OFS: begin
               if (!busy) begin
                  d.base = pwdata_i[9:0];
               end
            end
            adc_host_pkg::MUXADR_OFS: begin
               if (!busy) begin
                  d.mux_addr = pwdata_i[9:0];
               end
            end
            default: begin
            end
         endcase
      end

      // ----------------------------------------
      // i/o cycle sequencer
      // ----------------------------------------
      case (q.state)
         adc_host_pkg::ST_IDLE: begin
            d.io_read_strobe   = 1'b0;
            d.io_write_strobe   = 1'b0;
            d.drive = 1'b0;
            if (!io_address_enable_n_i && q.pend_conv) begin
               d.pend_conv = 1'b0;
               d.conv_op   = 1'b1;
               d.io_addr   = {q.base[9:1], 1'b0};
               d.wdata     = {6'h00, q.cmd_byte[1:0]};
               d.mode      = q.cmd_byte[adc_host_pkg::MODE_W-1:0];
               d.io_write_strobe       = 1'b1;
               d.drive     = 1'b1;
               d.cnt       = CW'(adc_host_pkg::T_W_CYC - 1);
               d.state     = adc_host_pkg::ST_WR_STROBE;
            end else if (!io_address_enable_n_i && q.pend_mux) begin
               d.pend_mux = 1'b0;
               d.conv_op  = 1'b0;
               d.io_addr  = q.mux_addr;
               d.wdata    = {6'h00, q.cmd_byte[adc_host_pkg::CHAN_W-1:0]};
               d.io_write_strobe      = 1'b1;
               d.drive    = 1'b1;
               d.cnt      = CW'(adc_host_pkg::T_W_CYC - 1);
               d.state    = adc_host_pkg::ST_WR_STROBE;
            end
         end

         adc_host_pkg::ST_WR_STROBE: begin
            if (q.cnt == '0) begin
               d.io_write_strobe   = 1'b0;
               d.cnt   = CW'(adc_host_pkg::T_DH_CYC);
               d.state = adc_host_pkg::ST_WR_HOLD;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end

         adc_host_pkg::ST_WR_HOLD: begin
            // data held past the strobe's end
            if (q.cnt == '0) begin
               d.drive = 1'b0;
               if (q.conv_op) begin
                  d.cnt   = CW'(adc_host_pkg::T_CV_CYC - 1);
                  d.state = adc_host_pkg::ST_CONV_WAIT;
               end else begin
                  d.cnt   = CW'(adc_host_pkg::T_DT_CYC - 1);
                  d.state = adc_host_pkg::ST_RECOVER;
               end
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end

         adc_host_pkg::ST_CONV_WAIT: begin
            if (q.cnt == '0) begin
               d.state = adc_host_pkg::ST_STATUS_WAIT;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end

         adc_host_pkg::ST_STATUS_WAIT: begin
            // read only once status is low
            if (!conv_status_i && !io_address_enable_n_i) begin
               d.io_addr = {q.base[9:1], 1'b1};
               d.io_read_strobe     = 1'b1;
               d.cnt     = CW'(adc_host_pkg::T_TD_CYC);
               d.state   = adc_host_pkg::ST_RD_STROBE;
            end
         end

         adc_host_pkg::ST_RD_STROBE: begin
            if (q.cnt == '0) begin
               d.result = conv_data_i;
               d.io_read_strobe    = 1'b0;
               d.cnt    = CW'(adc_host_pkg::T_DT_CYC);
               d.state  = adc_host_pkg::ST_RECOVER;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end

         adc_host_pkg::ST_RECOVER: begin
            // lets the data outputs float again
            if (q.cnt == '0) begin
               d.done  = 1'b1;
               d.state = adc_host_pkg::ST_IDLE;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end

         default: begin
            d.state = adc_host_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q.state     <= adc_host_pkg::ST_IDLE;
         q.cnt       <= '0;
         q.conv_op   <= 1'b0;
         q.pend_conv <= 1'b0;
         q.pend_mux  <= 1'b0;
         q.io_addr   <= 10'h000;
         q.io_read_strobe       <= 1'b0;
         q.io_write_strobe       <= 1'b0;
         q.drive     <= 1'b0;
         q.wdata     <= 8'h00;
         q.cmd_byte  <= 8'h00;
         q.base      <= adc_host_pkg::CONV_BASE_RST;
         q.mux_addr  <= adc_host_pkg::MUX_ADDR_RST;
         q.result    <= 8'h00;
         q.mode      <= adc_host_pkg::MODE_UNI_STRAIGHT;
         q.done      <= 1'b0;
         q.pready    <= 1'b0;
         q.pslverr   <= 1'b0;
         q.prdata    <= 32'h0000_0000;
      end else begin
         q <= d;
      end
   end

   assign prdata_o  = q.prdata;
   assign pready_o  = q.pready;
   assign pslverr_o = q.pslverr;

   // ----------------------------------------
   // pin glue
   // ----------------------------------------
   adc_io_glue u_glue (
      .mclk_i                (mclk_i),
      .resetn_i              (resetn_i),
      .io_addr_i             (q.io_addr),
      .io_address_enable_n_i (io_address_enable_n_i),
      .io_read_strobe_i      (q.io_read_strobe),
      .io_write_strobe_i     (q.io_write_strobe),
      .io_drive_i            (q.drive),
      .io_wdata_i            (q.wdata),
      .conv_base_i           (q.base),
      .mux_addr_i            (q.mux_addr),
      .conv_status_i         (conv_status_i),
      .conv_cs_n_o           (conv_cs_n_o),
      .conv_ce_n_o           (conv_ce_n_o),
      .conv_rw_o             (conv_rw_o),
      .conv_data_o           (conv_data_o),
      .conv_data_oe_o        (conv_data_oe_o),
      .mux_chan_o            (mux_chan_o),
      .sample_o              (sample_o)
   );

endmodule

// ===== dv/adc_host_ctrl_assertions.sv
`timescale 1ns/1ps

module adc_host_ctrl_assertions (
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        io_address_enable_n_i,
   input wire logic        conv_status_i,
   input wire logic [7:0]  conv_data_i,
   input wire logic        conv_cs_n_o,
   input wire logic        conv_ce_n_o,
   input wire logic        conv_rw_o,
   input wire logic [7:0]  conv_data_o,
   input wire logic        conv_data_oe_o,
   input wire logic [1:0]  mux_chan_o,
   input wire logic        sample_o
);
   localparam int unsigned READ_GAP = 2500;
   logic [11:0] wid_q;
   logic [11:0] gap_q;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   // ----------------------------------------
   // strobe width and start-to-read spacing
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wid_q <= 12'h000;
         gap_q <= 12'hfff;
      end else begin
         wid_q <= conv_ce_n_o ? 12'h000 : wid_q + 12'h001;
         if (!conv_ce_n_o && !conv_rw_o) begin
            gap_q <= 12'h000;
         end else if (gap_q != 12'hfff) begin
            gap_q <= gap_q + 12'h001;
         end
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_dma_no_select: assert property (io_address_enable_n_i && $past(io_address_enable_n_i) |->
      conv_cs_n_o && conv_ce_n_o) else $error("converter selected during dma cycle");
   a_enable_needs_decode: assert property (!conv_ce_n_o |-> !conv_cs_n_o)
      else $error("chip enable low without address decode");
   a_sample_inverts: assert property (sample_o == !$past(conv_status_i))
      else $error("sample control not inverse of status");
   a_no_busy_strobe: assert property (conv_status_i && $past(conv_status_i) |-> conv_ce_n_o)
      else $error("strobe issued while converting");
   a_rw_steady: assert property (!conv_ce_n_o && $past(!conv_ce_n_o) |-> $stable(conv_rw_o))
      else $error("direction changed inside strobe");
   a_upper_bits_zero: assert property (!conv_ce_n_o && !conv_rw_o |-> conv_data_o[7:2] == 6'h00)
      else $error("upper start bits not zero");
   a_start_width: assert property ($rose(conv_ce_n_o) && !$past(conv_rw_o) |->
      wid_q >= adc_host_pkg::T_W_CYC) else $error("start strobe too short");
   a_data_hold: assert property ($rose(conv_ce_n_o) && !$past(conv_rw_o) |->
      (conv_data_oe_o && $stable(conv_data_o)) [*3]) else $error("start data not held");
   a_read_wait: assert property ($fell(conv_ce_n_o) && conv_rw_o |-> gap_q >= READ_GAP)
      else $error("result read too soon after start");
   a_read_width: assert property ($rose(conv_ce_n_o) && $past(conv_rw_o) |->
      wid_q >= adc_host_pkg::T_TD_CYC) else $error("read strobe too short");
   a_mux_latch: assert property ($changed(mux_chan_o) |-> conv_data_oe_o && conv_cs_n_o)
      else $error("channel changed outside mux write");
   a_apb_answer: assert property ($rose(penable_i) && psel_i |=> pready_o)
      else $error("apb answer late");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");

   c_start: cover property ($fell(conv_ce_n_o) && !conv_rw_o);
   c_read: cover property ($fell(conv_ce_n_o) && conv_rw_o);
   c_mux: cover property ($changed(mux_chan_o));
   c_err: cover property (pslverr_o);
endmodule

// ===== dv/adc_conv_model.sv
`timescale 1ns/1ps

module adc_conv_model #(
   parameter int unsigned CONV_CYC = 2500
) (
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic       cs_n_i,
   input  wire logic       ce_n_i,
   input  wire logic       rw_i,
   input  wire logic [7:0] data_i,
   output logic            status_o,
   output logic [7:0]      data_o,
   output logic [7:0]      n_conv_o,
   output logic [7:0]      start_byte_o
);
   logic [11:0] low_q;
   logic [11:0] busy_q;
   logic [7:0]  res_q;
   logic [7:0]  last_q;
   logic        start_on;
   logic        rd_en;

   assign start_on = !cs_n_i && !ce_n_i && !rw_i;
   assign rd_en = !cs_n_i && !ce_n_i && rw_i && !status_o;
   // released bus shows a changing pattern
   assign data_o = rd_en ? res_q : ~last_q;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_q        <= 12'h000;
         busy_q       <= 12'h000;
         res_q        <= 8'h00;
         last_q       <= 8'h00;
         status_o     <= 1'b0;
         n_conv_o     <= 8'h00;
         start_byte_o <= 8'h00;
      end else begin
         last_q <= data_o;
         // starts ignored while busy, whole byte kept
         if (start_on) begin
            low_q <= low_q + 12'h001;
            if (!status_o) begin
               start_byte_o <= data_i;
            end
         end else begin
            if (low_q >= adc_host_pkg::T_W_CYC && !status_o) begin
               status_o <= 1'b1;
               busy_q   <= 12'(CONV_CYC);
               n_conv_o <= n_conv_o + 8'h01;
               // distinct code per mode
               res_q    <= 8'h50 + {6'h00, start_byte_o[1:0]};
            end
            low_q <= 12'h000;
         end
         if (status_o) begin
            busy_q <= busy_q - 12'h001;
            if (busy_q == 12'h001) begin
               status_o <= 1'b0;
            end
         end
      end
   end
endmodule

// ===== dv/test_adc_host_ctrl.sv
`timescale 1ns/1ps

module test_adc_host_ctrl;
   logic        mclk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        io_address_enable_n_i = 1'b0;
   logic        conv_status_i;
   logic [7:0]  conv_data_i;
   logic        conv_cs_n_o;
   logic        conv_ce_n_o;
   logic        conv_rw_o;
   logic [7:0]  conv_data_o;
   logic        conv_data_oe_o;
   logic [1:0]  mux_chan_o;
   logic        sample_o;
   logic [7:0]  n_conv;
   logic [7:0]  start_byte;
   logic [7:0]  conv_n;
   logic [31:0] rd_q;
   logic        err_q;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          i;

   always #2 mclk_i = ~mclk_i;

   adc_host_ctrl i_adc_host_ctrl (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .io_address_enable_n_i(io_address_enable_n_i),
      .conv_status_i(conv_status_i), .conv_data_i(conv_data_i), .conv_cs_n_o(conv_cs_n_o),
      .conv_ce_n_o(conv_ce_n_o), .conv_rw_o(conv_rw_o), .conv_data_o(conv_data_o),
      .conv_data_oe_o(conv_data_oe_o), .mux_chan_o(mux_chan_o), .sample_o(sample_o)
   );

   adc_conv_model i_adc_conv_model (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(conv_cs_n_o), .ce_n_i(conv_ce_n_o),
      .rw_i(conv_rw_o), .data_i(conv_data_o), .status_o(conv_status_i), .data_o(conv_data_i),
      .n_conv_o(n_conv), .start_byte_o(start_byte)
   );

   // ----------------------------------------
   // verdict, compare and bus tasks
   // ----------------------------------------
   task automatic close_out();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      for (k = 0; k < 32; k++) begin
         @(posedge mclk_i);
         if (pready_o === 1'b1) break;
      end
      if (k == 32) begin
         n_mismatch++;
         close_out();
      end
      rd_q = prdata_o;
      err_q = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wait_done();
      int k;
      for (k = 0; k < 400; k++) begin
         repeat (16) @(posedge mclk_i);
         apb(1'b0, adc_host_pkg::STATUS_OFS, 32'h0);
         if (rd_q[adc_host_pkg::ST_DONE_BIT] === 1'b1) break;
      end
      if (k == 400) begin
         n_mismatch++;
         close_out();
      end
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      check(32'(sample_o), 32'h1);
      apb(1'b0, adc_host_pkg::BASE_OFS, 32'h0);
      check(rd_q, 32'h310);
      apb(1'b0, adc_host_pkg::MUXADR_OFS, 32'h0);
      check(rd_q, 32'h318);
      apb(1'b0, 12'h020, 32'h0);
      check(32'(err_q), 32'h1);
      for (i = 0; i < 4; i++) begin
         conv_n = n_conv;
         apb(1'b1, adc_host_pkg::CMD_OFS, 32'h1fc | i);
         wait_done();
         check(32'(start_byte), i);
         check(32'(n_conv), 32'(conv_n + 8'h01));
         apb(1'b0, adc_host_pkg::RESULT_OFS, 32'h0);
         check(rd_q, 32'h50 + i);
         apb(1'b0, adc_host_pkg::STATUS_OFS, 32'h0);
         check(32'(rd_q[17:16]), i);
      end
      conv_n = n_conv;
      apb(1'b1, adc_host_pkg::CMD_OFS, 32'h103);
      repeat (200) @(posedge mclk_i);
      apb(1'b1, adc_host_pkg::BASE_OFS, 32'h2a0);
      apb(1'b1, adc_host_pkg::CMD_OFS, 32'h100);
      wait_done();
      apb(1'b0, adc_host_pkg::BASE_OFS, 32'h0);
      check(rd_q, 32'h310);
      check(32'(n_conv), 32'(conv_n + 8'h01));
      conv_n = n_conv;
      io_address_enable_n_i <= 1'b1;
      apb(1'b1, adc_host_pkg::CMD_OFS, 32'h101);
      repeat (100) @(posedge mclk_i);
      check(32'(n_conv), 32'(conv_n));
      io_address_enable_n_i <= 1'b0;
      wait_done();
      check(32'(n_conv), 32'(conv_n + 8'h01));
      apb(1'b1, adc_host_pkg::CMD_OFS, 32'h202);
      wait_done();
      check(32'(mux_chan_o), 32'h2);
      check(32'(n_conv), 32'(conv_n + 8'h01));
      apb(1'b1, adc_host_pkg::CMD_OFS, 32'h101);
      wait_done();
      check(32'(mux_chan_o), 32'h2);
      check(32'(n_conv), 32'(conv_n + 8'h02));
      close_out();
   end
endmodule

bind adc_host_ctrl adc_host_ctrl_assertions i_adc_host_ctrl_assertions (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .io_address_enable_n_i(io_address_enable_n_i),
   .conv_status_i(conv_status_i), .conv_data_i(conv_data_i), .conv_cs_n_o(conv_cs_n_o),
   .conv_ce_n_o(conv_ce_n_o), .conv_rw_o(conv_rw_o), .conv_data_o(conv_data_o),
   .conv_data_oe_o(conv_data_oe_o), .mux_chan_o(mux_chan_o), .sample_o(sample_o)
);
